// ---- hdl/rsl_limits_top.sv ----
// settings bank for reference slew rate and thermistor fault/warning thresholds
//
// Summary of operation
// - while the converter is on, a new setpoint is reached by ramping the reference gradually at the selected slew rate.
// - turning the converter on or off moves the reference at once, without the slew limit.
// - the 3-bit slew code picks 12.5 mV/ms at code 0, doubling per code up to 1600 mV/ms.
// - the slew-rate setting resets to 0x0004, a ramp of 200 mV/ms.
// - the slew-rate setting is a 16-bit read/write word whose bits 15 to 3 do nothing.
// - the fault threshold is a 16-bit read/write word with a 2 mV-per-count level in bits 9 to 0.
// - the fault flag is raised whenever the thermistor sample is below the fault threshold.
// - the fault threshold resets to 0x0096, that is 300 mV.
// - the warning threshold is a 16-bit read/write word with a 2 mV-per-count level in bits 9 to 0.
// - the warning flag is raised whenever the thermistor sample is below the warning threshold.
// - the warning threshold resets to 0x00e1, that is 450 mV.
// - the setpoint word holds the reference as an 8-bit count of 8 mV, the target of the ramp.
// - while the write lock covers ordinary commands, writes to the settings are dropped but reads work.
`timescale 1ns/1ps
module rsl_limits_top #(
   parameter int unsigned STEP_BASE_CYCLES = rsl_pkg::SLOWEST_STEP_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire rsl_pkg::rsl_cmd_req_t cmd_req_i,
   input wire logic [7:0] wp_mode_i,
   input wire logic conv_on_i,
   input wire logic adc_sclk_i,
   input wire logic [rsl_pkg::THR_W-1:0] adc_data_i,
   output logic [rsl_pkg::REG_W-1:0] rdata_o,
   output logic rd_valid_o,
   output logic wr_refused_o,
   output logic [rsl_pkg::REF_W-1:0] ref_level_o,
   output logic ramp_busy_o,
   output logic [rsl_pkg::THR_W-1:0] thermistor_sample_o,
   output logic board_overtemp_fault_o,
   output logic board_overtemp_warning_o
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // true when the write lock forbids a write to the given command
   function automatic logic write_blocked(input logic [7:0] mode, input logic [7:0] code);
      logic blk;
      blk = 1'b0;
      if (mode == rsl_pkg::WP_LOCK_ALL || mode == rsl_pkg::WP_KEEP_ONOFF) begin
         blk = 1'b1;
      end else if (mode == rsl_pkg::WP_KEEP_SETPOINT) begin
         blk = (code != rsl_pkg::CMD_SETPOINT);
      end
      return blk;
   endfunction : write_blocked

   // a lower thermistor voltage means a hotter board
   function automatic logic below_limit(input logic [rsl_pkg::THR_W-1:0] sample,
                                        input logic [rsl_pkg::REG_W-1:0] limit_word);
      return sample < limit_word[rsl_pkg::THR_W-1:0];
   endfunction : below_limit

   function automatic logic is_mapped(input logic [7:0] code);
      return (code == rsl_pkg::CMD_SETPOINT) || (code == rsl_pkg::CMD_SLEW_RATE) ||
             (code == rsl_pkg::CMD_FAULT_THR) || (code == rsl_pkg::CMD_WARN_THR);
   endfunction : is_mapped

   // ---------------------------------------------------------------
   // settings
   // ---------------------------------------------------------------

   logic [rsl_pkg::REG_W-1:0] setpoint_q;
   logic [rsl_pkg::REG_W-1:0] slew_rate_q;
   logic [rsl_pkg::REG_W-1:0] fault_thr_q;
   logic [rsl_pkg::REG_W-1:0] warn_thr_q;
   logic wr_ok;
   logic wr_locked;

   assign wr_ok = cmd_req_i.wr && !write_blocked(wp_mode_i, cmd_req_i.code);
   assign wr_locked = cmd_req_i.wr && is_mapped(cmd_req_i.code) && write_blocked(wp_mode_i, cmd_req_i.code);

   // all sixteen bits are stored so a read returns what was written,
   // even though only the low bits steer anything
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         setpoint_q <= rsl_pkg::SETPOINT_RST;
         slew_rate_q <= rsl_pkg::SLEW_RATE_RST;
         fault_thr_q <= rsl_pkg::FAULT_THR_RST;
         warn_thr_q <= rsl_pkg::WARN_THR_RST;
      end else if (wr_ok) begin
         unique case (cmd_req_i.code)
            rsl_pkg::CMD_SETPOINT: begin
               setpoint_q <= cmd_req_i.wdata;
            end
            rsl_pkg::CMD_SLEW_RATE: begin
               slew_rate_q <= cmd_req_i.wdata;
            end
            rsl_pkg::CMD_FAULT_THR: begin
               fault_thr_q <= cmd_req_i.wdata;
            end
            rsl_pkg::CMD_WARN_THR: begin
               warn_thr_q <= cmd_req_i.wdata;
            end
            default: begin
               // other codes belong to other blocks
            end
         endcase
      end
   end

   // read answer, one cycle after the request; unknown codes read zero
   logic [rsl_pkg::REG_W-1:0] rdata_q;
   logic rd_valid_q;
   logic wr_refused_q;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= '0;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= cmd_req_i.rd;
         if (cmd_req_i.rd) begin
            // reads stay open whatever the write lock says
            unique case (cmd_req_i.code)
               rsl_pkg::CMD_SETPOINT: begin
                  rdata_q <= setpoint_q;
               end
               rsl_pkg::CMD_SLEW_RATE: begin
                  rdata_q <= slew_rate_q;
               end
               rsl_pkg::CMD_FAULT_THR: begin
                  rdata_q <= fault_thr_q;
               end
               rsl_pkg::CMD_WARN_THR: begin
                  rdata_q <= warn_thr_q;
               end
               default: begin
                  rdata_q <= '0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_refused_q <= 1'b0;
      end else begin
         wr_refused_q <= wr_locked;
      end
   end

   // ---------------------------------------------------------------
   // reference ramp
   // ---------------------------------------------------------------

   logic [rsl_pkg::REF_W-1:0] ref_level;
   logic ramp_busy_q;

   // while off, the reference simply follows the setpoint, so turn-on
   // starts at the commanded level and is not slew limited
   rsl_ref_ramp #(
      .BASE_CYCLES(rsl_pkg::STEP_CNT_W'(STEP_BASE_CYCLES))
   ) u_ramp (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .bypass_i(!conv_on_i),
      .target_i(setpoint_q[rsl_pkg::REF_W-1:0]),
      .rate_code_i(slew_rate_q[rsl_pkg::SLEW_CODE_W-1:0]),
      .level_o(ref_level)
   );

   // lags the level by one cycle
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ramp_busy_q <= 1'b0;
      end else begin
         ramp_busy_q <= conv_on_i && (ref_level != setpoint_q[rsl_pkg::REF_W-1:0]);
      end
   end

   // ---------------------------------------------------------------
   // thermistor sample capture and comparison
   // ---------------------------------------------------------------

   // the sample clock and data come from outside; both pass two flops,
   // and the data is taken on the synchronised rising edge, which relies
   // on the converter holding data steady around that edge
   logic sclk_s1_q;
   logic sclk_s2_q;
   logic sclk_s3_q;
   logic [rsl_pkg::THR_W-1:0] data_s1_q;
   logic [rsl_pkg::THR_W-1:0] data_s2_q;
   logic sample_edge;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         data_s1_q <= '0;
         data_s2_q <= '0;
      end else begin
         sclk_s1_q <= adc_sclk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         data_s1_q <= adc_data_i;
         data_s2_q <= data_s1_q;
      end
   end

   assign sample_edge = sclk_s2_q && !sclk_s3_q;

   logic [rsl_pkg::THR_W-1:0] sample_q;
   rsl_pkg::rsl_thermal_flags_t flags_q;

   // flags change only on a new sample; a threshold write takes effect
   // at the next sample, which avoids a glitch mid-write
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sample_q <= '0;
         flags_q <= '0;
      end else if (sample_edge) begin
         sample_q <= data_s2_q;
         flags_q.fault <= below_limit(data_s2_q, fault_thr_q);
         flags_q.warning <= below_limit(data_s2_q, warn_thr_q);
      end
   end

   assign rdata_o = rdata_q;
   assign rd_valid_o = rd_valid_q;
   assign wr_refused_o = wr_refused_q;
   assign ref_level_o = ref_level;
   assign ramp_busy_o = ramp_busy_q;
   assign thermistor_sample_o = sample_q;
   assign board_overtemp_fault_o = flags_q.fault;
   assign board_overtemp_warning_o = flags_q.warning;

endmodule : rsl_limits_top

// ---- hdl/rsl_pkg.sv ----
// shared constants and types for the reference slew and thermal limit block
package rsl_pkg;

   // command codes of the settings held by this block
   localparam logic [7:0] CMD_SETPOINT = 8'h21;
   localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
   localparam logic [7:0] CMD_FAULT_THR = 8'h4f;
   localparam logic [7:0] CMD_WARN_THR = 8'h51;

   // reset values of the settings
   localparam logic [15:0] SETPOINT_RST = 16'h00c8;
   localparam logic [15:0] SLEW_RATE_RST = 16'h0004;
   localparam logic [15:0] FAULT_THR_RST = 16'h0096;
   localparam logic [15:0] WARN_THR_RST = 16'h00e1;

   // field layouts
   localparam int REG_W = 16;
   localparam int REF_W = 8;
   localparam int SLEW_CODE_W = 3;
   localparam int THR_W = 10;

   // write-lock modes; any other value leaves every write open
   localparam logic [7:0] WP_LOCK_ALL = 8'h80;
   localparam logic [7:0] WP_KEEP_ONOFF = 8'h40;
   localparam logic [7:0] WP_KEEP_SETPOINT = 8'h20;

   // ramp timing: one 8 mV count at the slowest rate of 12.5 mV/ms
   localparam int CLK_PERIOD_NS = 8;
   localparam int REF_STEP_UV = 8000;
   localparam int SLOWEST_RATE_UV_PER_MS = 12500;
   localparam int SLOWEST_STEP_NS = REF_STEP_UV * 1000 / SLOWEST_RATE_UV_PER_MS * 1000;
   localparam int SLOWEST_STEP_CYC = SLOWEST_STEP_NS / CLK_PERIOD_NS;
   localparam int STEP_CNT_W = 17;

   // one request from the serial command engine
   typedef struct packed {
      logic [7:0] code;
      logic wr;
      logic rd;
      logic [REG_W-1:0] wdata;
   } rsl_cmd_req_t;

   // thermistor comparison results
   typedef struct packed {
      logic fault;
      logic warning;
   } rsl_thermal_flags_t;

endpackage : rsl_pkg

// ---- hdl/rsl_ref_ramp.sv ----
// reference ramp generator: walks the reference count toward its target one count at a time
`timescale 1ns/1ps
module rsl_ref_ramp #(
   parameter logic [rsl_pkg::STEP_CNT_W-1:0] BASE_CYCLES = rsl_pkg::STEP_CNT_W'(rsl_pkg::SLOWEST_STEP_CYC)
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic bypass_i,
   input wire logic [rsl_pkg::REF_W-1:0] target_i,
   input wire logic [rsl_pkg::SLEW_CODE_W-1:0] rate_code_i,
   output logic [rsl_pkg::REF_W-1:0] level_o
);

   localparam logic [rsl_pkg::STEP_CNT_W-1:0] CNT_ONE = rsl_pkg::STEP_CNT_W'(1);
   localparam logic [rsl_pkg::REF_W-1:0] REF_ONE = rsl_pkg::REF_W'(1);

   logic [rsl_pkg::STEP_CNT_W-1:0] cnt_q;
   logic [rsl_pkg::REF_W-1:0] level_q;
   logic [rsl_pkg::STEP_CNT_W-1:0] interval;
   logic moving;
   logic step_due;

   // each code up doubles the rate, so the step interval halves
   assign interval = BASE_CYCLES >> rate_code_i;
   assign moving = !bypass_i && (level_q != target_i);
   // a shortened base may give a zero interval; then the ramp steps every cycle
   assign step_due = moving && ((cnt_q + CNT_ONE) >= interval);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else if (!moving || step_due) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_ONE;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         level_q <= rsl_pkg::SETPOINT_RST[rsl_pkg::REF_W-1:0];
      end else if (bypass_i) begin
         level_q <= target_i;
      end else if (step_due) begin
         // single-count steps cannot overshoot the target
         if (level_q < target_i) begin
            level_q <= level_q + REF_ONE;
         end else begin
            level_q <= level_q - REF_ONE;
         end
      end
   end

   assign level_o = level_q;

endmodule : rsl_ref_ramp

// ---- dv/rsl_limits_sva.sv ----
// assertions on the command, write-lock and ramp ports of the limits bank
`timescale 1ns/1ps
module rsl_limits_sva (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire rsl_pkg::rsl_cmd_req_t cmd_req_i,
   input wire logic [7:0] wp_mode_i,
   input wire logic conv_on_i,
   input wire logic [rsl_pkg::REG_W-1:0] rdata_o,
   input wire logic rd_valid_o,
   input wire logic wr_refused_o,
   input wire logic [rsl_pkg::REF_W-1:0] ref_level_o,
   input wire logic ramp_busy_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic mapped;
   assign mapped = cmd_req_i.code inside {8'h21, 8'h27, 8'h4f, 8'h51};
   sequence rd_req_s;
      cmd_req_i.rd;
   endsequence
   sequence steady_on_s;
      conv_on_i && $past(conv_on_i) && $past(conv_on_i, 2);
   endsequence
   rd_answer_a: assert property (rd_req_s |=> rd_valid_o) else $error("read not answered");
   rd_quiet_a: assert property (!cmd_req_i.rd |=> !rd_valid_o) else $error("stray read valid");
   rdata_hold_a: assert property ($changed(rdata_o) |-> rd_valid_o) else $error("read data moved");
   lock_refuse_a: assert property (cmd_req_i.wr && mapped && wp_mode_i inside {8'h80, 8'h40}
      |=> wr_refused_o) else $error("locked write not refused");
   lock_partial_a: assert property (cmd_req_i.wr && wp_mode_i == 8'h20 && mapped && cmd_req_i.code != 8'h21
      |=> wr_refused_o) else $error("partial lock let a write through");
   lock_setpoint_a: assert property (cmd_req_i.wr && wp_mode_i == 8'h20 && cmd_req_i.code == 8'h21
      |=> !wr_refused_o) else $error("partial lock refused setpoint");
   open_write_a: assert property (cmd_req_i.wr && !(wp_mode_i inside {8'h80, 8'h40, 8'h20})
      |=> !wr_refused_o) else $error("open write refused");
   refuse_cause_a: assert property (wr_refused_o |-> $past(cmd_req_i.wr)) else $error("refusal without write");
   ramp_off_a: assert property ((!conv_on_i) [*2] |=> !ramp_busy_o) else $error("ramp busy while off");
   ramp_step_a: assert property (steady_on_s ##0 $changed(ref_level_o) |->
      ref_level_o == $past(ref_level_o) + 8'h01 || ref_level_o == $past(ref_level_o) - 8'h01)
      else $error("reference jumped");
endmodule : rsl_limits_sva

// ---- dv/rsl_thermistor_src.sv ----
// thermistor converter model: one parallel sample per rising edge of its sample clock
`timescale 1ns/1ps
module rsl_thermistor_src (
   output logic sclk_o,
   output logic [rsl_pkg::THR_W-1:0] data_o
);
   initial begin
      sclk_o = 1'b0;
      data_o = 10'h000;
   end
   // clock idles low between samples; data flips after the frame so a stale word never looks valid
   task automatic send(input logic [rsl_pkg::THR_W-1:0] v);
      data_o = v;
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
      data_o = ~v;
   endtask : send
endmodule : rsl_thermistor_src

// ---- dv/rsl_limits_tb.sv ----
// self-checking bench for the reference slew and thermal limits bank
`timescale 1ns/1ps
module rsl_limits_tb;
   typedef struct {logic [7:0] code; logic wr; logic [15:0] wdata; logic [15:0] exp;} rsl_row_t;
   logic clk;
   logic rst_b;
   rsl_pkg::rsl_cmd_req_t req;
   logic [7:0] wp;
   logic conv_on;
   logic sclk;
   logic [9:0] adc;
   logic [15:0] rdata;
   logic rd_valid;
   logic wr_ref;
   logic [7:0] ref_lvl;
   logic busy;
   logic [9:0] sample;
   logic fault;
   logic warn;
   int err_count = 0;
   int check_count = 0;
   rsl_row_t rows[8] = '{'{8'h27, 1'b0, 16'h0, 16'h0004}, '{8'h4f, 1'b0, 16'h0, 16'h0096},
      '{8'h51, 1'b0, 16'h0, 16'h00e1}, '{8'h33, 1'b0, 16'h0, 16'h0000}, '{8'h33, 1'b1, 16'h1234, 16'h0000},
      '{8'h4f, 1'b1, 16'hfc05, 16'hfc05}, '{8'h51, 1'b1, 16'ha3ff, 16'ha3ff}, '{8'h27, 1'b1, 16'h5558, 16'h5558}};
   logic [9:0] smp[6] = '{10'h0ff, 10'h100, 10'h17f, 10'h180, 10'h3ff, 10'h000};

   rsl_limits_top #(.STEP_BASE_CYCLES(16)) dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .cmd_req_i(req),
      .wp_mode_i(wp), .conv_on_i(conv_on), .adc_sclk_i(sclk), .adc_data_i(adc), .rdata_o(rdata),
      .rd_valid_o(rd_valid), .wr_refused_o(wr_ref), .ref_level_o(ref_lvl), .ramp_busy_o(busy),
      .thermistor_sample_o(sample), .board_overtemp_fault_o(fault), .board_overtemp_warning_o(warn));
   rsl_thermistor_src src_u (.sclk_o(sclk), .data_o(adc));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic do_reset();
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
   endtask : do_reset

   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic refused);
      @(negedge clk);
      req = '{code: c, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk);
      req.wr = 1'b0;
      chk({15'h0, wr_ref}, {15'h0, refused}, "write refusal");
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      @(negedge clk);
      req.code = c;
      req.rd = 1'b1;
      @(negedge clk);
      req.rd = 1'b0;
      chk({15'h0, rd_valid}, 16'h0001, "read valid");
      chk(rdata, e, "read data");
   endtask : rd

   // one count per interval; a second step inside the settle window would be an overshoot
   task automatic step_wait(input int lo, input logic up);
      logic [7:0] tgt;
      int n;
      tgt = up ? ref_lvl + 8'h01 : ref_lvl - 8'h01;
      n = 0;
      while (ref_lvl !== tgt && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (n == 40) begin
         chk(16'h0, 16'h1, "ramp timeout");
         report_and_stop();
      end else begin
         chk(16'(n), 16'(lo), "step interval");
         chk({15'h0, busy}, 16'h0001, "busy while ramping");
         repeat (lo + 3) @(negedge clk);
         chk({8'h00, ref_lvl}, {8'h00, tgt}, "ramp end");
         chk({15'h0, busy}, 16'h0000, "busy after ramp");
      end
   endtask : step_wait

   initial begin
      req = '0;
      wp = 8'h00;
      conv_on = 1'b0;
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].code, rows[i].wdata, 1'b0);
         rd(rows[i].code, rows[i].exp);
      end
      $display("done: register table");
      wp = 8'h80;
      wr(8'h27, 16'h0001, 1'b1);
      wr(8'h33, 16'h0001, 1'b0);
      wp = 8'h40;
      wr(8'h21, 16'h0020, 1'b1);
      wp = 8'h20;
      wr(8'h21, 16'h0010, 1'b0);
      wr(8'h4f, 16'h0001, 1'b1);
      rd(8'h27, 16'h5558);
      rd(8'h4f, 16'hfc05);
      wp = 8'h00;
      repeat (2) @(negedge clk);
      chk({8'h00, ref_lvl}, 16'h0010, "direct setpoint");
      $display("done: write lock and converter off");
      conv_on = 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr(8'h27, 16'hfff8 | 16'(c), 1'b0);
         wr(8'h21, {8'h00, ref_lvl + 8'h01}, 1'b0);
         step_wait((16 >> c) > 0 ? 16 >> c : 1, 1'b1);
      end
      wr(8'h27, 16'h0002, 1'b0);
      wr(8'h21, {8'h00, ref_lvl - 8'h01}, 1'b0);
      step_wait(4, 1'b0);
      $display("done: ramp rates");
      wr(8'h4f, 16'hfd00, 1'b0);
      wr(8'h51, 16'h7d80, 1'b0);
      foreach (smp[i]) begin
         src_u.send(smp[i]);
         @(negedge clk);
         chk({6'h00, sample}, {6'h00, smp[i]}, "sample");
         chk({14'h0, fault, warn}, {14'h0, smp[i] < 10'h100, smp[i] < 10'h180}, "flags");
      end
      $display("done: thermal flags");
      do_reset();
      rd(8'h51, 16'h00e1);
      $display("done: second reset");
      report_and_stop();
   end
endmodule : rsl_limits_tb

bind rsl_limits_top rsl_limits_sva chk_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_req_i(cmd_req_i),
   .wp_mode_i(wp_mode_i), .conv_on_i(conv_on_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
   .wr_refused_o(wr_refused_o), .ref_level_o(ref_level_o), .ramp_busy_o(ramp_busy_o));
